/* File: sfs_flag_bank.sv */
// Bank of sticky fault and warning flags.
// Assumes set and clear come from the same clock domain.
`timescale 1ns/10ps
module sfs_flag_bank #(
	parameter int W = 19
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Flag carrier
	sfs_flag_if.bank flags
);
	typedef struct packed {
		logic [W-1:0] bits;
	} sfs_bank_state_t;

	sfs_bank_state_t state_q;
	sfs_bank_state_t state_d;

	if (W < 1) begin : g_chk
		$error("sfs_flag_bank: W must be at least 1");
	end

	always_comb begin
		state_d = state_q;
		if (flags.clr) begin
			state_d.bits = '0;
		end
		state_d.bits = state_d.bits | flags.set;
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign flags.q = state_q.bits;
endmodule

/* File: sfs_flag_if.sv */
// Interface carrying sticky flag set, clear and stored value.
// Assumes one owner (the flag bank) and one user (the register group).
`timescale 1ns/10ps
interface sfs_flag_if #(parameter int W = 19);
	logic [W-1:0] set;
	logic clr;
	logic [W-1:0] q;
	modport bank (input set, input clr, output q);
	modport user (output set, output clr, input q);
endinterface

/* File: sfs_host_model.sv */
// Host model issuing one command at a time on the command port.
// Assumes the register group answers one clock after each strobe.
`timescale 1ns/10ps
module sfs_host_model (
	// Clock
	input wire logic i_mclk,
	// Command port
	output logic o_cmd_valid,
	output logic o_cmd_write,
	output logic [7:0] o_cmd_code,
	output logic [15:0] o_cmd_wdata,
	input wire logic i_rsp_valid,
	input wire logic [15:0] i_rsp_data,
	input wire logic i_rsp_err
);
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_write = 1'b0;
		o_cmd_code = 8'h00;
		o_cmd_wdata = 16'h0000;
	end
	// Word sent whole; read wdata toggles with the strobe and the code toggles after it, so stale values never look valid
	task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] rd, output logic err, output logic ok);
		int n;
		@(posedge i_mclk);
		o_cmd_valid <= 1'b1;
		o_cmd_write <= wr;
		o_cmd_code <= c;
		o_cmd_wdata <= wr ? d : ~o_cmd_wdata;
		@(posedge i_mclk);
		o_cmd_valid <= 1'b0;
		o_cmd_code <= ~c;
		ok = 1'b0;
		for (n = 0; n < 4 && !ok; n++) begin
			@(negedge i_mclk);
			ok = (i_rsp_valid === 1'b1);
		end
		rd = i_rsp_data;
		err = i_rsp_err;
	endtask
endmodule

/* File: sfs_pkg.sv */
// Constants for the sequencing timing and fault status register group.
// Assumes command codes arrive from a serial bus link layer outside this block.
package sfs_pkg;
	// Command codes
	localparam logic [7:0] CMD_START_DELAY = 8'h60;
	localparam logic [7:0] CMD_RAMP_UP_TIME = 8'h61;
	localparam logic [7:0] CMD_STOP_DELAY = 8'h64;
	localparam logic [7:0] CMD_RAMP_DOWN_TIME = 8'h65;
	localparam logic [7:0] CMD_FAULT_SUMMARY_BYTE = 8'h78;
	localparam logic [7:0] CMD_FAULT_SUMMARY_WORD = 8'h79;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_FLAGS = 8'h7a;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_FLAGS = 8'h7b;
	localparam logic [7:0] CMD_INPUT_FLAGS = 8'h7c;

	// Reset values: timing 5 ms in linear-11 (exponent 0, mantissa 5), status byte and word zero
	localparam logic [15:0] TIMING_RESET = 16'h0005;
	localparam logic [7:0] STATUS_BYTE_RESET = 8'h00;
	localparam logic [15:0] STATUS_WORD_RESET = 16'h0000;

	// Accepted ranges in ms
	localparam int START_DELAY_MAX_MS = 500;
	localparam int RAMP_UP_MAX_MS = 200;
	localparam int STOP_DELAY_MAX_MS = 500;
	localparam int RAMP_DOWN_MAX_MS = 200;

	// Linear-11 field layout
	localparam int L11_MANT_MSB = 10;
	localparam int L11_EXP_LSB = 11;

	// Sticky flag vector positions
	localparam int FL_OUT_OV_FAULT = 0;
	localparam int FL_OUT_OV_WARN = 1;
	localparam int FL_OUT_UV_WARN = 2;
	localparam int FL_OUT_UV_FAULT = 3;
	localparam int FL_OC_FAULT = 4;
	localparam int FL_OC_LV_FAULT = 5;
	localparam int FL_OC_WARN = 6;
	localparam int FL_UC_FAULT = 7;
	localparam int FL_IN_OV_FAULT = 8;
	localparam int FL_IN_OV_WARN = 9;
	localparam int FL_IN_UV_WARN = 10;
	localparam int FL_IN_UV_FAULT = 11;
	localparam int FL_BUSY = 12;
	localparam int FL_TEMP = 13;
	localparam int FL_CML = 14;
	localparam int FL_OTHER = 15;
	localparam int FL_MAKER = 16;
	localparam int FL_FANS = 17;
	localparam int FL_UNKNOWN = 18;
	localparam int FL_COUNT = 19;

	// Summary byte bit positions
	localparam int SB_BUSY = 7;
	localparam int SB_OFF = 6;
	localparam int SB_OUT_OV = 5;
	localparam int SB_OC = 4;
	localparam int SB_IN_UV = 3;
	localparam int SB_TEMP = 2;
	localparam int SB_CML = 1;
	localparam int SB_OTHER = 0;

	// Summary word high byte positions
	localparam int SW_VOUT = 15;
	localparam int SW_IOUT = 14;
	localparam int SW_INPUT = 13;
	localparam int SW_MAKER = 12;
	localparam int SW_PG_N = 11;
	localparam int SW_FANS = 10;
	localparam int SW_MISC = 9;
	localparam int SW_UNKNOWN = 8;
endpackage

/* File: sfs_regs.sv */
// Sequencing timing and fault status register group, reached by command code.
// Assumes a link layer presents one command per i_cmd_valid pulse; inputs synchronous.
`timescale 1ns/10ps
module sfs_regs (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Command port
	input wire logic i_cmd_valid,
	input wire logic i_cmd_write,
	input wire logic [7:0] i_cmd_code,
	input wire logic [15:0] i_cmd_wdata,
	input wire logic i_clear_faults,
	output logic o_rsp_valid,
	output logic [15:0] o_rsp_data,
	output logic o_rsp_err,
	// Fault and warning events
	input wire logic i_ev_out_overvolt_fault,
	input wire logic i_ev_out_overvolt_warn,
	input wire logic i_ev_out_undervolt_warn,
	input wire logic i_ev_out_undervolt_fault,
	input wire logic i_ev_overcurrent_fault,
	input wire logic i_ev_overcurrent_lowvolt_fault,
	input wire logic i_ev_overcurrent_warn,
	input wire logic i_ev_undercurrent_fault,
	input wire logic i_ev_in_overvolt_fault,
	input wire logic i_ev_in_overvolt_warn,
	input wire logic i_ev_in_undervolt_warn,
	input wire logic i_ev_in_undervolt_fault,
	input wire logic i_ev_busy,
	input wire logic i_ev_temperature,
	input wire logic i_ev_comms_logic_memory,
	input wire logic i_ev_maker_specific,
	input wire logic i_ev_fans,
	input wire logic i_ev_other_fault,
	input wire logic i_ev_unknown,
	// Live conditions
	input wire logic i_output_on,
	input wire logic i_vout_above_pg_on,
	input wire logic i_vout_below_uv_fault,
	input wire logic i_misc_flags_any,
	// Outputs to the power stage and host
	output logic [15:0] o_start_delay,
	output logic [15:0] o_ramp_up_time,
	output logic [15:0] o_stop_delay,
	output logic [15:0] o_ramp_down_time,
	output logic o_power_good,
	output logic o_alert
);
	typedef struct packed {
		logic [15:0] start_delay;
		logic [15:0] ramp_up_time;
		logic [15:0] stop_delay;
		logic [15:0] ramp_down_time;
		logic pg;
		logic rsp_valid;
		logic [15:0] rsp_data;
		logic rsp_err;
	} sfs_regs_state_t;

	sfs_regs_state_t state_q;
	sfs_regs_state_t state_d;

	sfs_flag_if #(.W(sfs_pkg::FL_COUNT)) flags ();

	logic cmd_fault;
	logic [7:0] out_voltage_flags;
	logic [7:0] out_current_flags;
	logic [7:0] in_flags;
	logic [7:0] summary_byte;
	logic [15:0] summary_word;

	////////////////////////////////////////////////////////////////////////////////
	// Linear-11 range check: mantissa * 2^exponent within 0..max_ms
	function automatic logic l11_in_range(input logic [15:0] v, input int max_ms);
		int m;
		int e;
		logic ok;
		m = int'($signed(v[sfs_pkg::L11_MANT_MSB:0]));
		e = int'($signed(v[15:sfs_pkg::L11_EXP_LSB]));
		if (m < 0) begin
			ok = 1'b0;
		end else if (e >= 0) begin
			ok = (m << e) <= max_ms;
		end else begin
			ok = m <= (max_ms << (-e));
		end
		return ok;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Sticky flags
	sfs_flag_bank #(
		.W(sfs_pkg::FL_COUNT)
	) u_flags (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.flags(flags)
	);

	always_comb begin
		flags.set = '0;
		flags.set[sfs_pkg::FL_OUT_OV_FAULT] = i_ev_out_overvolt_fault;
		flags.set[sfs_pkg::FL_OUT_OV_WARN] = i_ev_out_overvolt_warn;
		flags.set[sfs_pkg::FL_OUT_UV_WARN] = i_ev_out_undervolt_warn;
		flags.set[sfs_pkg::FL_OUT_UV_FAULT] = i_ev_out_undervolt_fault;
		flags.set[sfs_pkg::FL_OC_FAULT] = i_ev_overcurrent_fault;
		flags.set[sfs_pkg::FL_OC_LV_FAULT] = i_ev_overcurrent_lowvolt_fault;
		flags.set[sfs_pkg::FL_OC_WARN] = i_ev_overcurrent_warn;
		flags.set[sfs_pkg::FL_UC_FAULT] = i_ev_undercurrent_fault;
		flags.set[sfs_pkg::FL_IN_OV_FAULT] = i_ev_in_overvolt_fault;
		flags.set[sfs_pkg::FL_IN_OV_WARN] = i_ev_in_overvolt_warn;
		flags.set[sfs_pkg::FL_IN_UV_WARN] = i_ev_in_undervolt_warn;
		flags.set[sfs_pkg::FL_IN_UV_FAULT] = i_ev_in_undervolt_fault;
		flags.set[sfs_pkg::FL_BUSY] = i_ev_busy;
		flags.set[sfs_pkg::FL_TEMP] = i_ev_temperature;
		flags.set[sfs_pkg::FL_CML] = i_ev_comms_logic_memory | cmd_fault;
		flags.set[sfs_pkg::FL_OTHER] = i_ev_other_fault | i_ev_in_overvolt_warn
			| i_ev_in_undervolt_warn;
		flags.set[sfs_pkg::FL_MAKER] = i_ev_maker_specific;
		flags.set[sfs_pkg::FL_FANS] = i_ev_fans;
		flags.set[sfs_pkg::FL_UNKNOWN] = i_ev_unknown;
	end

	assign flags.clr = i_clear_faults;

	////////////////////////////////////////////////////////////////////////////////
	// Status register composition
	assign out_voltage_flags = {flags.q[sfs_pkg::FL_OUT_OV_FAULT],
		flags.q[sfs_pkg::FL_OUT_OV_WARN], flags.q[sfs_pkg::FL_OUT_UV_WARN],
		flags.q[sfs_pkg::FL_OUT_UV_FAULT], 4'h0};
	assign out_current_flags = {flags.q[sfs_pkg::FL_OC_FAULT],
		flags.q[sfs_pkg::FL_OC_LV_FAULT], flags.q[sfs_pkg::FL_OC_WARN],
		flags.q[sfs_pkg::FL_UC_FAULT], 4'h0};
	assign in_flags = {flags.q[sfs_pkg::FL_IN_OV_FAULT],
		flags.q[sfs_pkg::FL_IN_OV_WARN], flags.q[sfs_pkg::FL_IN_UV_WARN],
		flags.q[sfs_pkg::FL_IN_UV_FAULT], 4'h0};

	always_comb begin
		summary_byte = sfs_pkg::STATUS_BYTE_RESET;
		summary_byte[sfs_pkg::SB_BUSY] = flags.q[sfs_pkg::FL_BUSY];
		summary_byte[sfs_pkg::SB_OFF] = ~i_output_on;
		summary_byte[sfs_pkg::SB_OUT_OV] = flags.q[sfs_pkg::FL_OUT_OV_FAULT];
		summary_byte[sfs_pkg::SB_OC] = flags.q[sfs_pkg::FL_OC_FAULT];
		summary_byte[sfs_pkg::SB_IN_UV] = flags.q[sfs_pkg::FL_IN_UV_FAULT];
		summary_byte[sfs_pkg::SB_TEMP] = flags.q[sfs_pkg::FL_TEMP];
		summary_byte[sfs_pkg::SB_CML] = flags.q[sfs_pkg::FL_CML];
		summary_byte[sfs_pkg::SB_OTHER] = flags.q[sfs_pkg::FL_OTHER];
	end

	always_comb begin
		summary_word = sfs_pkg::STATUS_WORD_RESET;
		summary_word[7:0] = summary_byte;
		summary_word[sfs_pkg::SW_VOUT] = |out_voltage_flags;
		summary_word[sfs_pkg::SW_IOUT] = |out_current_flags;
		summary_word[sfs_pkg::SW_INPUT] = |in_flags;
		summary_word[sfs_pkg::SW_MAKER] = flags.q[sfs_pkg::FL_MAKER];
		summary_word[sfs_pkg::SW_PG_N] = ~state_q.pg;
		summary_word[sfs_pkg::SW_FANS] = flags.q[sfs_pkg::FL_FANS];
		summary_word[sfs_pkg::SW_MISC] = i_misc_flags_any;
		summary_word[sfs_pkg::SW_UNKNOWN] = flags.q[sfs_pkg::FL_UNKNOWN];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command decode, timing registers and power-good
	always_comb begin
		state_d = state_q;
		cmd_fault = 1'b0;
		state_d.rsp_valid = i_cmd_valid;
		state_d.rsp_err = 1'b0;
		state_d.rsp_data = 16'h0000;
		if (state_q.pg) begin
			state_d.pg = ~i_vout_below_uv_fault;
		end else begin
			state_d.pg = i_vout_above_pg_on;
		end
		if (i_cmd_valid) begin
			case (i_cmd_code)
				sfs_pkg::CMD_START_DELAY: begin
					if (!i_cmd_write) begin
						state_d.rsp_data = state_q.start_delay;
					end else if (l11_in_range(i_cmd_wdata, sfs_pkg::START_DELAY_MAX_MS)) begin
						state_d.start_delay = i_cmd_wdata;
					end else begin
						cmd_fault = 1'b1;
					end
				end
				sfs_pkg::CMD_RAMP_UP_TIME: begin
					if (!i_cmd_write) begin
						state_d.rsp_data = state_q.ramp_up_time;
					end else if (l11_in_range(i_cmd_wdata, sfs_pkg::RAMP_UP_MAX_MS)) begin
						state_d.ramp_up_time = i_cmd_wdata;
					end else begin
						cmd_fault = 1'b1;
					end
				end
				sfs_pkg::CMD_STOP_DELAY: begin
					if (!i_cmd_write) begin
						state_d.rsp_data = state_q.stop_delay;
					end else if (l11_in_range(i_cmd_wdata, sfs_pkg::STOP_DELAY_MAX_MS)) begin
						state_d.stop_delay = i_cmd_wdata;
					end else begin
						cmd_fault = 1'b1;
					end
				end
				sfs_pkg::CMD_RAMP_DOWN_TIME: begin
					if (!i_cmd_write) begin
						state_d.rsp_data = state_q.ramp_down_time;
					end else if (l11_in_range(i_cmd_wdata, sfs_pkg::RAMP_DOWN_MAX_MS)) begin
						state_d.ramp_down_time = i_cmd_wdata;
					end else begin
						cmd_fault = 1'b1;
					end
				end
				sfs_pkg::CMD_FAULT_SUMMARY_BYTE: begin
					state_d.rsp_data = {8'h00, summary_byte};
					cmd_fault = i_cmd_write;
				end
				sfs_pkg::CMD_FAULT_SUMMARY_WORD: begin
					state_d.rsp_data = summary_word;
					cmd_fault = i_cmd_write;
				end
				sfs_pkg::CMD_OUTPUT_VOLTAGE_FLAGS: begin
					state_d.rsp_data = {8'h00, out_voltage_flags};
					cmd_fault = i_cmd_write;
				end
				sfs_pkg::CMD_OUTPUT_CURRENT_FLAGS: begin
					state_d.rsp_data = {8'h00, out_current_flags};
					cmd_fault = i_cmd_write;
				end
				sfs_pkg::CMD_INPUT_FLAGS: begin
					state_d.rsp_data = {8'h00, in_flags};
					cmd_fault = i_cmd_write;
				end
				default: begin
					cmd_fault = 1'b1;
				end
			endcase
			if (cmd_fault) begin
				state_d.rsp_data = 16'h0000;
			end
			state_d.rsp_err = cmd_fault;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_q.start_delay <= sfs_pkg::TIMING_RESET;
			state_q.ramp_up_time <= sfs_pkg::TIMING_RESET;
			state_q.stop_delay <= sfs_pkg::TIMING_RESET;
			state_q.ramp_down_time <= sfs_pkg::TIMING_RESET;
			state_q.pg <= 1'b0;
			state_q.rsp_valid <= 1'b0;
			state_q.rsp_data <= 16'h0000;
			state_q.rsp_err <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign o_rsp_valid = state_q.rsp_valid;
	assign o_rsp_data = state_q.rsp_data;
	assign o_rsp_err = state_q.rsp_err;
	assign o_start_delay = state_q.start_delay;
	assign o_ramp_up_time = state_q.ramp_up_time;
	assign o_stop_delay = state_q.stop_delay;
	assign o_ramp_down_time = state_q.ramp_down_time;
	assign o_power_good = state_q.pg;
	assign o_alert = |flags.q;
endmodule

/* File: sfs_regs_asserts.sv */
// Concurrent checks on the command port, sticky flags and power-good.
// Assumes it is bound to sfs_regs and sees only that module's ports.
`timescale 1ns/10ps
module sfs_regs_asserts (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Command port
	input wire logic i_cmd_valid,
	input wire logic i_cmd_write,
	input wire logic [7:0] i_cmd_code,
	input wire logic [15:0] i_cmd_wdata,
	input wire logic i_clear_faults,
	input wire logic o_rsp_valid,
	input wire logic [15:0] o_rsp_data,
	input wire logic o_rsp_err,
	// Live state and results
	input wire logic i_ev_fans,
	input wire logic i_output_on,
	input wire logic i_vout_above_pg_on,
	input wire logic i_vout_below_uv_fault,
	input wire logic [15:0] o_start_delay,
	input wire logic o_power_good,
	input wire logic o_alert
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	////////////////////////////////////////////////////////////////////////////////
	sequence s_wr(logic [7:0] c, logic [15:0] d);
		i_cmd_valid && i_cmd_write && i_cmd_code == c && i_cmd_wdata == d;
	endsequence
	sequence s_fan_quiet;
		i_ev_fans ##1 !i_clear_faults [*3];
	endsequence
	chk_rsp_follows: assert property (i_cmd_valid |=> o_rsp_valid)
		else $error("no answer one cycle after a command");
	chk_rsp_no_spur: assert property (!i_cmd_valid |=> !o_rsp_valid)
		else $error("answer without a command");
	chk_ro_write_err: assert property (i_cmd_valid && i_cmd_write
		&& i_cmd_code inside {[8'h78:8'h7c]} |=> o_rsp_err && o_rsp_data == 16'h0000)
		else $error("status write not refused");
	chk_unknown_err: assert property (i_cmd_valid && !(i_cmd_code inside
		{8'h60, 8'h61, 8'h64, 8'h65, [8'h78:8'h7c]}) |=> o_rsp_err)
		else $error("unknown code not refused");
	chk_start_max: assert property (s_wr(8'h60, 16'h01f4)
		|=> !o_rsp_err && o_start_delay == 16'h01f4)
		else $error("largest start delay not stored");
	chk_start_over: assert property (s_wr(8'h60, 16'h01f5)
		|=> o_rsp_err && o_start_delay == $past(o_start_delay))
		else $error("start delay above range stored");
	chk_off_bit: assert property (i_cmd_valid && !i_cmd_write && i_cmd_code == 8'h78
		|=> o_rsp_data[6] != $past(i_output_on) && o_rsp_data[15:8] == 8'h00)
		else $error("summary off bit wrong");
	chk_flag_sticky: assert property (s_fan_quiet |-> o_alert)
		else $error("flag lost before clear");
	chk_pg_rise: assert property (!i_rst && !o_power_good && i_vout_above_pg_on
		&& !i_vout_below_uv_fault |=> o_power_good)
		else $error("power good did not assert");
	chk_pg_fall: assert property (o_power_good && i_vout_below_uv_fault
		&& !i_vout_above_pg_on |=> !o_power_good)
		else $error("power good did not drop");
endmodule
bind sfs_regs sfs_regs_asserts u_chk (.i_mclk, .i_rst, .i_cmd_valid, .i_cmd_write,
	.i_cmd_code, .i_cmd_wdata, .i_clear_faults, .o_rsp_valid, .o_rsp_data, .o_rsp_err,
	.i_ev_fans, .i_output_on, .i_vout_above_pg_on, .i_vout_below_uv_fault,
	.o_start_delay, .o_power_good, .o_alert);

/* File: tb_top.sv */
// Self-checking bench for the sequencing timing and fault status registers.
// Assumes sfs_pkg, sfs_regs, the checker and the host model are compiled first.
`timescale 1ns/10ps
module tb_top;
	logic i_mclk, i_rst, clr, out_on, pg_on, uv_lo, misc, pg, alert;
	logic cmd_valid, cmd_write, rsp_valid, rsp_err;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata, rsp_data, msk;
	logic [18:0] ev;
	logic [15:0] tval [4];
	int mismatches, num_checks, cyc, i;
	logic [7:0] tcode [4] = '{8'h60, 8'h61, 8'h64, 8'h65};
	logic [15:0] tmax [4] = '{16'h01f4, 16'h00c8, 16'h01f4, 16'h00c8};
	logic [15:0] exp_w [19] = '{16'h8020, 16'h8000, 16'h8000, 16'h8000, 16'h4010, 16'h4000,
		16'h4000, 16'h4000, 16'h2000, 16'h2001, 16'h2001, 16'h2008, 16'h0080, 16'h0004,
		16'h0002, 16'h0001, 16'h1000, 16'h0400, 16'h0100};
	////////////////////////////////////////////////////////////////////////////////
	sfs_host_model u_host (.i_mclk(i_mclk), .o_cmd_valid(cmd_valid), .o_cmd_write(cmd_write),
		.o_cmd_code(cmd_code), .o_cmd_wdata(cmd_wdata), .i_rsp_valid(rsp_valid),
		.i_rsp_data(rsp_data), .i_rsp_err(rsp_err));
	sfs_regs u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_cmd_valid(cmd_valid),
		.i_cmd_write(cmd_write), .i_cmd_code(cmd_code), .i_cmd_wdata(cmd_wdata),
		.i_clear_faults(clr), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
		.o_rsp_err(rsp_err), .i_ev_out_overvolt_fault(ev[0]), .i_ev_out_overvolt_warn(ev[1]),
		.i_ev_out_undervolt_warn(ev[2]), .i_ev_out_undervolt_fault(ev[3]),
		.i_ev_overcurrent_fault(ev[4]), .i_ev_overcurrent_lowvolt_fault(ev[5]),
		.i_ev_overcurrent_warn(ev[6]), .i_ev_undercurrent_fault(ev[7]),
		.i_ev_in_overvolt_fault(ev[8]), .i_ev_in_overvolt_warn(ev[9]),
		.i_ev_in_undervolt_warn(ev[10]), .i_ev_in_undervolt_fault(ev[11]),
		.i_ev_busy(ev[12]), .i_ev_temperature(ev[13]), .i_ev_comms_logic_memory(ev[14]),
		.i_ev_other_fault(ev[15]), .i_ev_maker_specific(ev[16]), .i_ev_fans(ev[17]),
		.i_ev_unknown(ev[18]), .i_output_on(out_on), .i_vout_above_pg_on(pg_on),
		.i_vout_below_uv_fault(uv_lo), .i_misc_flags_any(misc), .o_start_delay(tval[0]),
		.o_ramp_up_time(tval[1]), .o_stop_delay(tval[2]), .o_ramp_down_time(tval[3]),
		.o_power_good(pg),
		.o_alert(alert));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask
	task automatic chk_bit(input string what, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %b, seen %b", what, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e_err);
		logic [15:0] got;
		logic err, ok;
		u_host.xfer(1'b1, c, d, got, err, ok);
		chk_bit($sformatf("answer to write %h", c), 1'b1, ok);
		chk_bit($sformatf("refusal of write %h", c), e_err, err);
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] e, input logic [15:0] m);
		logic [15:0] got;
		logic err, ok;
		u_host.xfer(1'b0, c, 16'h0000, got, err, ok);
		chk_bit($sformatf("answer to read %h", c), 1'b1, ok && !err);
		chk16($sformatf("read of %h", c), e & m, got & m);
	endtask
	task automatic clear_flags();
		@(posedge i_mclk);
		clr <= 1'b1;
		@(posedge i_mclk);
		clr <= 1'b0;
	endtask
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			print_verdict();
		end
	end
	initial begin
		{i_rst, out_on, pg_on} = 3'b111;
		{clr, uv_lo, misc, ev} = '0;
		repeat (5) @(posedge i_mclk);
		i_rst <= 1'b0;
		for (i = 0; i < 4; i++) begin
			rd(tcode[i], 16'h0005, 16'hffff);
			chk16("timing output after reset", 16'h0005, tval[i]);
		end
		for (i = 0; i < 5; i++) rd(8'(8'h78 + i), 16'h0000, 16'hffff);
		for (i = 0; i < 4; i++) begin
			wr(tcode[i], tmax[i], 1'b0);
			wr(tcode[i], tmax[i] + 16'h0001, 1'b1);
			rd(tcode[i], tmax[i], 16'hffff);
			chk16("timing output", tmax[i], tval[i]);
		end
		wr(8'h61, 16'h0865, 1'b1);
		wr(8'h61, 16'h0864, 1'b0);
		rd(8'h61, 16'h0864, 16'hffff);
		wr(8'h60, 16'h07ff, 1'b1);
		wr(8'h60, 16'hfbe9, 1'b1);
		wr(8'h60, 16'hfbe8, 1'b0);
		rd(8'h60, 16'hfbe8, 16'hffff);
		wr(8'h79, 16'h0000, 1'b1);
		wr(8'h62, 16'h0000, 1'b1);
		rd(8'h78, 16'h0002, 16'hfffe);
		clear_flags();
		rd(8'h79, 16'h0000, 16'hffff);
		for (i = 0; i < 19; i++) begin
			msk = (i == 9 || i == 10 || i == 15) ? 16'hffff : 16'hfffe;
			@(posedge i_mclk);
			ev[i] <= 1'b1;
			@(posedge i_mclk);
			ev <= '0;
			@(negedge i_mclk);
			chk_bit("alert after event", 1'b1, alert);
			repeat (3) @(posedge i_mclk);
			rd(8'h79, exp_w[i], msk);
			if (i < 12) begin
				rd(8'(8'h7a + i / 4), {8'h00, 8'(8'h80 >> (i % 4))}, msk);
			end else begin
				rd(8'h78, {8'h00, exp_w[i][7:0]}, msk);
			end
			clear_flags();
			@(negedge i_mclk);
			chk_bit("alert after clear", 1'b0, alert);
		end
		@(posedge i_mclk);
		out_on <= 1'b0;
		rd(8'h78, 16'h0040, 16'hfffe);
		@(posedge i_mclk);
		{out_on, uv_lo, pg_on} <= 3'b110;
		rd(8'h79, 16'h0800, 16'hfffe);
		chk_bit("power good low", 1'b0, pg);
		@(posedge i_mclk);
		{uv_lo, pg_on, misc} <= 3'b011;
		rd(8'h79, 16'h0200, 16'hffff);
		chk_bit("power good high", 1'b1, pg);
		// Reset in mid-run with a flag set and timing values written
		@(posedge i_mclk);
		{misc, ev[17]} <= 2'b01;
		@(posedge i_mclk);
		ev <= '0;
		@(negedge i_mclk);
		chk_bit("alert before reset", 1'b1, alert);
		@(posedge i_mclk);
		i_rst <= 1'b1;
		@(negedge i_mclk);
		chk_bit("alert in reset", 1'b0, alert);
		repeat (5) @(posedge i_mclk);
		i_rst <= 1'b0;
		rd(8'h79, 16'h0000, 16'hffff);
		for (i = 0; i < 4; i++) begin
			rd(tcode[i], 16'h0005, 16'hffff);
			chk16("timing output after reset", 16'h0005, tval[i]);
		end
		print_verdict();
	end
endmodule
